// file: hw/cmd_fifo_pkg.sv
// Functional notes
// - queue entries hold subchannel, method, 32-bit parameter and mode flag.
// - method 0 binds or rebinds the subchannel to an engine or memory object.
// - methods 0 to 0xfc run inside the puller, bound object ignored.
// - method byte number is index times four; index 0x3f is 0xfc.
// - non-increasing flag is stored but never steers execution.
// - pusher queues accepted commands; puller forwards to engine or driver.
// - switcher slices time and saves/restores channel state per switch.
// - channels select programmed, linear fetch or indirect fetch submission.
// - programmed-write support set by variant: all, first 32 or channel 0.
// - big-endian by channel flag or global switch swaps fetch data.
// - control area byte order follows only the register-space endian switch.
// - objects are named by arbitrary 32-bit handles; memory or engine kind.
// - indirect mode joins pieces of several memory areas into one stream.
// - rearchitected variant reports three active channels; the switcher still tracks one.
// - software pseudo-engine commands above 0xfc raise an interrupt every command.
package cmd_fifo_pkg;
    localparam int SUBC_W = 3;
    localparam int MTHD_W = 12;
    localparam int DATA_W = 32;
    localparam int CHAN_W = 7;
    localparam int ENG_W = 3;
    localparam logic [MTHD_W-1:0] SPECIAL_LAST = 12'h0FC;
    localparam logic [MTHD_W-1:0] MTHD_BIND = 12'h000;
    localparam logic [ENG_W-1:0] ENGINE_SOFTWARE = 3'h0;
    localparam logic [CHAN_W-1:0] PIO_LIMIT_MID = 7'h20;
    localparam int SLICE_CYCLES = 64;
    localparam int SAVE_CYCLES = 4;
    localparam int MAX_ACTIVE = 3;

    typedef enum logic [1:0] {
        MODE_PIO = 2'h0,
        MODE_LINEAR = 2'h1,
        MODE_INDIRECT = 2'h2
    } submit_mode_e;

    typedef enum logic [1:0] {
        PIO_ALL = 2'h0,
        PIO_FIRST32 = 2'h1,
        PIO_CHAN0 = 2'h2
    } pio_limit_e;

    typedef enum logic [1:0] {
        SW_RUN = 2'h0,
        SW_SAVE = 2'h1,
        SW_LOAD = 2'h3
    } switch_state_e;

    typedef struct packed {
        logic [SUBC_W-1:0] subc;
        logic [MTHD_W-1:0] mthd;
        logic [DATA_W-1:0] data;
        logic non_incr;
    } cmd_s;
endpackage

// file: hw/cmd_queue_if.sv
interface cmd_queue_if;
    import cmd_fifo_pkg::*;
    logic push_valid;
    logic push_ready;
    cmd_s push_cmd;
    logic pop_valid;
    logic pop_ready;
    cmd_s pop_cmd;
    logic empty;
    logic full;
    modport queue (input push_valid, push_cmd, pop_ready,
                   output push_ready, pop_valid, pop_cmd, empty, full);
    modport user (output push_valid, push_cmd, pop_ready,
                  input push_ready, pop_valid, pop_cmd, empty, full);
endinterface

// file: hw/cmd_queue.sv
module cmd_queue
    import cmd_fifo_pkg::*;
#(
    parameter int DEPTH = 8
) (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    cmd_queue_if.queue q
);
    localparam int AW = $clog2(DEPTH);
    cmd_s mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    wire do_push = q.push_valid && q.push_ready;
    wire do_pop = q.pop_valid && q.pop_ready;

    assign q.full = (count == (AW+1)'(DEPTH));
    assign q.empty = (count == '0);
    assign q.push_ready = !q.full;
    assign q.pop_valid = !q.empty;
    assign q.pop_cmd = mem[rd_ptr];

    always_ff @(posedge ref_clk_i) begin
        if (do_push) begin
            mem[wr_ptr] <= q.push_cmd;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            if (do_push) begin
                wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
            end
            if (do_pop) begin
                rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
            end
            count <= count + (AW+1)'(do_push) - (AW+1)'(do_pop);
        end
    end
endmodule

// file: hw/channel_command_queue_frontend.sv
module channel_command_queue_frontend
    import cmd_fifo_pkg::*;
#(
    parameter int DEPTH = 8,
    parameter int NUM_CHAN = 128
) (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    // ************************************************
    // configuration
    // ************************************************
    input wire logic [1:0] pio_limit_i,
    input wire logic global_big_endian_i,
    input wire logic chan_big_endian_i,
    input wire logic regspace_big_endian_i,
    input wire logic rearch_variant_i,
    input wire logic [1:0] chan_mode_i,
    input wire logic [CHAN_W-1:0] chan_i,
    // ************************************************
    // command submission
    // ************************************************
    input wire logic ctl_wr_i,
    input wire logic [DATA_W-1:0] ctl_wdata_i,
    input wire logic fetch_valid_i,
    input wire logic fetch_seg_last_i,
    input wire logic [DATA_W-1:0] fetch_word_i,
    input wire logic cmd_valid_i,
    input wire logic [SUBC_W-1:0] cmd_subc_i,
    input wire logic [MTHD_W-1:0] cmd_mthd_i,
    input wire logic [DATA_W-1:0] cmd_data_i,
    input wire logic cmd_non_incr_i,
    input wire logic cmd_from_fetch_i,
    output logic cmd_ready_o,
    output logic cmd_reject_o,
    output logic [DATA_W-1:0] ctl_data_o,
    output logic [DATA_W-1:0] fetch_data_o,
    output logic [15:0] stream_pieces_o,
    // ************************************************
    // puller inputs and outputs
    // ************************************************
    input wire logic [ENG_W-1:0] bind_engine_i,
    input wire logic bind_is_engine_i,
    input wire logic eng_ready_i,
    output logic eng_valid_o,
    output logic [ENG_W-1:0] eng_id_o,
    output logic [MTHD_W-1:0] eng_mthd_o,
    output logic [DATA_W-1:0] eng_data_o,
    output logic special_valid_o,
    output logic [MTHD_W-1:0] special_mthd_o,
    output logic [DATA_W-1:0] special_data_o,
    output logic sw_intr_o,
    output logic [DATA_W-1:0] bound_handle_o,
    // ************************************************
    // switcher
    // ************************************************
    input wire logic [CHAN_W-1:0] next_chan_i,
    input wire logic save_done_i,
    output logic save_req_o,
    output logic load_req_o,
    output logic [CHAN_W-1:0] active_chan_o,
    output logic [1:0] active_count_o
);
    function automatic logic [DATA_W-1:0] swap32(input logic [DATA_W-1:0] w);
        swap32 = {w[7:0], w[15:8], w[23:16], w[31:24]};
    endfunction

    cmd_queue_if qi();
    cmd_queue #(.DEPTH(DEPTH)) u_queue (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .q(qi)
    );

    // ************************************************
    // pusher
    // ************************************************
    wire pio_allowed = (pio_limit_i == PIO_ALL) ||
        (pio_limit_i == PIO_FIRST32 && chan_i < PIO_LIMIT_MID) ||
        (pio_limit_i == PIO_CHAN0 && chan_i == '0);
    wire mode_pio = (chan_mode_i == MODE_PIO);
    wire src_ok = cmd_from_fetch_i ? !mode_pio
        : (mode_pio && pio_allowed);
    wire fetch_be = global_big_endian_i || chan_big_endian_i;
    wire [DATA_W-1:0] next_fetch_data =
        fetch_be ? swap32(fetch_word_i) : fetch_word_i;
    wire [DATA_W-1:0] next_ctl_data =
        regspace_big_endian_i ? swap32(ctl_wdata_i) : ctl_wdata_i;

    assign qi.push_valid = cmd_valid_i && src_ok;
    assign qi.push_cmd = '{subc: cmd_subc_i, mthd: cmd_mthd_i,
        data: cmd_data_i, non_incr: cmd_non_incr_i};
    assign cmd_ready_o = qi.push_ready;
    assign cmd_reject_o = cmd_valid_i && !src_ok;

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            ctl_data_o <= '0;
            fetch_data_o <= '0;
            stream_pieces_o <= '0;
        end else begin
            if (ctl_wr_i) begin
                ctl_data_o <= next_ctl_data;
            end
            if (fetch_valid_i) begin
                fetch_data_o <= next_fetch_data;
            end
            // each finished piece joins the one stream
            if (fetch_valid_i && fetch_seg_last_i
                    && chan_mode_i == MODE_INDIRECT) begin
                stream_pieces_o <= stream_pieces_o + 16'h0001;
            end
        end
    end

    // ************************************************
    // puller
    // ************************************************
    logic [ENG_W-1:0] subc_engine [8];
    logic [DATA_W-1:0] subc_handle [8];
    wire cmd_s head = qi.pop_cmd;
    // method numbers are pre-multiplied byte addresses
    wire is_special = (head.mthd <= SPECIAL_LAST);
    wire is_bind = (head.mthd == MTHD_BIND);
    wire [ENG_W-1:0] head_engine = subc_engine[head.subc];
    wire out_busy = eng_valid_o && !eng_ready_i;
    // non_incr is never looked at here
    assign qi.pop_ready = !out_busy;
    wire take = qi.pop_valid && qi.pop_ready;

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            for (int i = 0; i < 8; i++) begin
                subc_engine[i] <= ENGINE_SOFTWARE;
                subc_handle[i] <= '0;
            end
        end else if (take && is_bind) begin
            // handle is an arbitrary 32-bit name
            subc_handle[head.subc] <= head.data;
            // memory-access objects leave the engine unchanged
            if (bind_is_engine_i) begin
                subc_engine[head.subc] <= bind_engine_i;
            end
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            eng_valid_o <= 1'b0;
            eng_id_o <= '0;
            eng_mthd_o <= '0;
            eng_data_o <= '0;
            special_valid_o <= 1'b0;
            special_mthd_o <= '0;
            special_data_o <= '0;
            sw_intr_o <= 1'b0;
            bound_handle_o <= '0;
        end else begin
            special_valid_o <= take && is_special;
            sw_intr_o <= take && !is_special
                && head_engine == ENGINE_SOFTWARE;
            if (take && is_special) begin
                special_mthd_o <= head.mthd;
                special_data_o <= head.data;
            end
            if (take && is_bind) begin
                bound_handle_o <= head.data;
            end
            if (take && !is_special) begin
                eng_valid_o <= 1'b1;
                eng_id_o <= head_engine;
                eng_mthd_o <= head.mthd;
                eng_data_o <= head.data;
            end else if (eng_ready_i) begin
                eng_valid_o <= 1'b0;
            end
        end
    end

    // ************************************************
    // switcher
    // ************************************************
    switch_state_e state;
    logic [6:0] slice;
    wire slice_done = (slice == 7'(SLICE_CYCLES - 1));

    assign save_req_o = (state == SW_SAVE);
    assign load_req_o = (state == SW_LOAD);

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            state <= SW_RUN;
            slice <= '0;
            active_chan_o <= '0;
            active_count_o <= 2'h1;
        end else begin
            // active count reads three when rearchitected, one otherwise; one active channel
            active_count_o <= rearch_variant_i ? 2'(MAX_ACTIVE) : 2'h1;
            case (state)
                SW_RUN: begin
                    slice <= slice + 7'h01;
                    if (slice_done && next_chan_i != active_chan_o) begin
                        state <= SW_SAVE;
                    end
                end
                SW_SAVE: begin
                    if (save_done_i) begin
                        state <= SW_LOAD;
                        active_chan_o <= next_chan_i;
                    end
                end
                SW_LOAD: begin
                    if (save_done_i) begin
                        state <= SW_RUN;
                        slice <= '0;
                    end
                end
                default: begin
                    state <= SW_RUN;
                end
            endcase
        end
    end
endmodule

// file: tb/engine_sink_model.sv
module engine_sink_model
    import cmd_fifo_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic stall_i,
    input wire logic eng_valid_o,
    input wire logic [DATA_W-1:0] eng_data_o,
    input wire logic save_req_o,
    input wire logic load_req_o,
    output logic eng_ready_i,
    output logic save_done_i = 1'b0
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [DATA_W-1:0] got [0:31];
    logic [1:0] dly = 2'h0;
    int cnt = 0;
    // ********
    // engine sink and save area
    // ********
    assign eng_ready_i = !stall_i;
    always @(posedge ref_clk_i) begin
        if (rst_i) begin
            cnt <= 0;
            dly <= 2'h0;
            save_done_i <= 1'b0;
        end else begin
            if (eng_valid_o && eng_ready_i) begin
                got[cnt[4:0]] <= eng_data_o;
                cnt <= cnt + 1;
            end
            // slow answer: three cycles per save or load
            dly <= (save_req_o || load_req_o) ? dly + 2'h1 : 2'h0;
            save_done_i <= (dly == 2'h2);
        end
    end
endmodule

// file: tb/channel_command_queue_frontend_monitor.sv
module channel_command_queue_frontend_monitor
    import cmd_fifo_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic [1:0] pio_limit_i,
    input wire logic regspace_big_endian_i,
    input wire logic rearch_variant_i,
    input wire logic [CHAN_W-1:0] chan_i,
    input wire logic ctl_wr_i,
    input wire logic [DATA_W-1:0] ctl_wdata_i,
    input wire logic cmd_valid_i,
    input wire logic cmd_from_fetch_i,
    input wire logic cmd_reject_o,
    input wire logic [DATA_W-1:0] ctl_data_o,
    input wire logic eng_ready_i,
    input wire logic eng_valid_o,
    input wire logic [MTHD_W-1:0] eng_mthd_o,
    input wire logic [DATA_W-1:0] eng_data_o,
    input wire logic special_valid_o,
    input wire logic [MTHD_W-1:0] special_mthd_o,
    input wire logic [CHAN_W-1:0] next_chan_i,
    input wire logic save_done_i,
    input wire logic save_req_o,
    input wire logic load_req_o,
    input wire logic [CHAN_W-1:0] active_chan_o,
    input wire logic [1:0] active_count_o
);
    wire logic [DATA_W-1:0] ctl_sw = {ctl_wdata_i[7:0], ctl_wdata_i[15:8],
        ctl_wdata_i[23:16], ctl_wdata_i[31:24]};
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (rst_i);
    sequence s_save_ack;
        save_req_o && save_done_i;
    endsequence
    sequence s_load_ack;
        load_req_o && save_done_i;
    endsequence
    a_eng_hold_stall: assert property (
        eng_valid_o && !eng_ready_i |=> eng_valid_o && $stable(eng_data_o)
        && $stable(eng_mthd_o)) else $error("engine word moved in stall");
    a_eng_not_special: assert property (
        eng_valid_o |-> eng_mthd_o > SPECIAL_LAST) else $error("low to eng");
    a_special_range: assert property (
        special_valid_o |-> special_mthd_o <= SPECIAL_LAST)
        else $error("high method run by puller");
    a_ctl_byte_order: assert property (
        ctl_wr_i |=> ctl_data_o == ($past(regspace_big_endian_i)
        ? $past(ctl_sw) : $past(ctl_wdata_i)))
        else $error("control area byte order");
    a_pio_chan_limit: assert property (
        cmd_valid_i && !cmd_from_fetch_i && pio_limit_i == PIO_CHAN0
        && chan_i != 7'h00 |-> cmd_reject_o) else $error("pio not refused");
    a_rearch_count: assert property (
        rearch_variant_i [*2] |-> active_count_o == 2'h3)
        else $error("active count");
    a_save_then_load: assert property (
        s_save_ack |=> load_req_o && active_chan_o == $past(next_chan_i))
        else $error("no load after save");
    a_load_then_run: assert property (
        s_load_ack |=> !load_req_o && !save_req_o) else $error("stuck load");
endmodule
bind channel_command_queue_frontend channel_command_queue_frontend_monitor
    mon_u (.*);

// file: tb/channel_command_queue_frontend_tb_top.sv
module channel_command_queue_frontend_tb_top
    import cmd_fifo_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic ref_clk_i = 1'b0, rst_i = 1'b1, stall = 1'b0, ok;
    logic [1:0] pio_limit_i = 2'h0, chan_mode_i = 2'h0;
    logic global_big_endian_i = 1'b0, chan_big_endian_i = 1'b0;
    logic regspace_big_endian_i = 1'b0, rearch_variant_i = 1'b0;
    logic [CHAN_W-1:0] chan_i = 7'h00, next_chan_i = 7'h00;
    logic ctl_wr_i = 1'b0, fetch_valid_i = 1'b0, fetch_seg_last_i = 1'b0;
    logic [DATA_W-1:0] ctl_wdata_i = 32'h0, fetch_word_i = 32'h0;
    logic cmd_valid_i = 1'b0, cmd_non_incr_i = 1'b0, cmd_from_fetch_i = 1'b0;
    logic [SUBC_W-1:0] cmd_subc_i = 3'h0;
    logic [MTHD_W-1:0] cmd_mthd_i = 12'h000, eng_mthd_o, special_mthd_o;
    logic [DATA_W-1:0] cmd_data_i = 32'h0, ctl_data_o, fetch_data_o;
    logic [DATA_W-1:0] eng_data_o, special_data_o, bound_handle_o;
    logic [ENG_W-1:0] bind_engine_i = 3'h1, eng_id_o;
    logic bind_is_engine_i = 1'b1, eng_ready_i, save_done_i, cmd_ready_o;
    logic cmd_reject_o, eng_valid_o, special_valid_o, sw_intr_o;
    logic save_req_o, load_req_o;
    logic [15:0] stream_pieces_o;
    logic [CHAN_W-1:0] active_chan_o;
    logic [1:0] active_count_o;
    int miscompares = 0, n_compared = 0, n, base;
    localparam int DEPTH = 8;
    `define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin \
        miscompares++; $display("BAD %0t %h %h", $time, a, b); end end
    channel_command_queue_frontend dut_u (.*);
    engine_sink_model model_u (.stall_i(stall), .*);
    initial begin
        forever #12.5 ref_clk_i = ~ref_clk_i;
    end
    task automatic cyc(input int k);
        repeat (k) @(posedge ref_clk_i);
    endtask
    task automatic stop_test();
        $display("compared %0d bad %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // gives up after 20 refused cycles
    task automatic put(input logic [SUBC_W-1:0] s,
        input logic [MTHD_W-1:0] m, input logic [DATA_W-1:0] d);
        int t;
        t = 0;
        cmd_valid_i <= 1'b1;
        cmd_subc_i <= s;
        cmd_mthd_i <= m;
        cmd_data_i <= d;
        cmd_non_incr_i <= d[0];
        do begin
            @(negedge ref_clk_i);
            ok = cmd_ready_o && !cmd_reject_o;
            t++;
            @(posedge ref_clk_i);
        end while (!ok && t < 20);
    endtask
    task automatic await(ref logic f);
        int t;
        t = 0;
        cmd_valid_i <= 1'b0;
        do begin
            @(negedge ref_clk_i);
            t++;
        end while (f !== 1'b1 && t < 150);
        `CHK(f, 1'b1)
    endtask
    task automatic rej(input logic [1:0] md, lim, input logic [6:0] ch,
        input logic e);
        chan_mode_i <= md;
        pio_limit_i <= lim;
        chan_i <= ch;
        cmd_valid_i <= 1'b1;
        @(negedge ref_clk_i);
        `CHK(cmd_reject_o, e)
        cyc(1);
    endtask
    initial begin
        #(25 * 4000);
        miscompares++;
        stop_test();
    end
    initial begin
        cyc(8);
        rst_i <= 1'b0;
        @(negedge ref_clk_i);
        `CHK(cmd_ready_o, 1'b1)
        `CHK(active_count_o, 2'h1)
        cyc(1);
        put(3'h1, MTHD_BIND, 32'hCAFE0001);
        await(special_valid_o);
        `CHK(special_data_o, 32'hCAFE0001)
        cyc(2);
        `CHK(bound_handle_o, 32'hCAFE0001)
        put(3'h1, SPECIAL_LAST, 32'h3F);
        await(special_valid_o);
        `CHK(special_mthd_o, 12'h0FC)
        cyc(1);
        put(3'h1, 12'h100, 32'h55);
        await(eng_valid_o);
        `CHK(eng_id_o, 3'h1)
        `CHK(eng_mthd_o, 12'h100)
        `CHK(eng_data_o, 32'h55)
        cyc(1);
        bind_is_engine_i <= 1'b0;
        put(3'h2, MTHD_BIND, 32'hBEEF0002);
        await(special_valid_o);
        `CHK(bound_handle_o, 32'hBEEF0002)
        cyc(1);
        put(3'h2, 12'h200, 32'h66);
        await(sw_intr_o);
        `CHK(eng_id_o, ENGINE_SOFTWARE)
        cyc(4);
        stall <= 1'b1;
        base = model_u.cnt;
        n = 0;
        do begin
            put(3'h1, 12'h104, n);
            n += ok;
        end while (ok && n < 20);
        cmd_valid_i <= 1'b0;
        stall <= 1'b0;
        `CHK(n >= DEPTH, 1'b1)
        for (int t = 0; t < 99 && model_u.cnt < base + n; t++) cyc(1);
        for (int k = 0; k < n; k++) `CHK(model_u.got[base + k], 32'(k))
        regspace_big_endian_i <= 1'b1;
        ctl_wr_i <= 1'b1;
        ctl_wdata_i <= 32'h12345678;
        cyc(1);
        regspace_big_endian_i <= 1'b0;
        chan_big_endian_i <= 1'b1;
        ctl_wdata_i <= 32'hCAFEBEEF;
        chan_mode_i <= MODE_INDIRECT;
        fetch_valid_i <= 1'b1;
        fetch_seg_last_i <= 1'b1;
        fetch_word_i <= 32'hA1B2C3D4;
        @(negedge ref_clk_i);
        `CHK(ctl_data_o, 32'h78563412)
        cyc(1);
        ctl_wr_i <= 1'b0;
        fetch_valid_i <= 1'b0;
        @(negedge ref_clk_i);
        `CHK(ctl_data_o, 32'hCAFEBEEF)
        `CHK(fetch_data_o, 32'hD4C3B2A1)
        `CHK(stream_pieces_o, 16'h0001)
        cyc(1);
        chan_big_endian_i <= 1'b0;
        global_big_endian_i <= 1'b1;
        fetch_valid_i <= 1'b1;
        fetch_word_i <= 32'h0A0B0C0D;
        cyc(1);
        fetch_valid_i <= 1'b0;
        @(negedge ref_clk_i);
        `CHK(fetch_data_o, 32'h0D0C0B0A)
        `CHK(stream_pieces_o, 16'h0002)
        cyc(1);
        rej(MODE_PIO, PIO_CHAN0, 7'h05, 1'b1);
        rej(MODE_PIO, PIO_FIRST32, 7'h20, 1'b1);
        rej(MODE_PIO, PIO_FIRST32, 7'h1F, 1'b0);
        rej(MODE_LINEAR, PIO_ALL, 7'h00, 1'b1);
        rearch_variant_i <= 1'b1;
        next_chan_i <= 7'h09;
        await(save_req_o);
        `CHK(active_count_o, 2'h3)
        await(load_req_o);
        `CHK(active_chan_o, 7'h09)
        cyc(6);
        @(negedge ref_clk_i);
        `CHK(load_req_o, 1'b0)
        `CHK(save_req_o, 1'b0)
        stop_test();
    end
endmodule
